// *** cabe_pkg.sv ***
// Purpose: Shared constants for the 8-bit core execution unit.
// Assumes: APB register map, byte addresses, 32-bit data.
// Notes:   Opcodes are codes of the command register.
`default_nettype none
package cabe_pkg;
  localparam int unsigned AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_OPA    = 8'h04;
  localparam logic [7:0] OFS_OPB    = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_PC     = 8'h10;
  localparam logic [7:0] OFS_ZPTR   = 8'h14;
  localparam logic [7:0] OFS_IOVAL  = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_STACK  = 8'h24;
  // Field positions
  localparam int unsigned FL_C = 0;
  localparam int unsigned FL_Z = 1;
  localparam int unsigned FL_N = 2;
  localparam int unsigned FL_V = 3;
  localparam int unsigned FL_S = 4;
  localparam int unsigned FL_H = 5;
  localparam int unsigned FL_T = 6;
  localparam int unsigned OPB_BIT_LSB  = 8;
  localparam int unsigned OPB_TWO_WORD = 11;
  localparam int unsigned ST_CYC_LSB   = 4;
  // Flag update masks
  localparam logic [7:0] MASK_ARITH = 8'h3F;
  localparam logic [7:0] MASK_WORD  = 8'h1F;
  localparam logic [7:0] MASK_LOGIC = 8'h1E;
  localparam logic [7:0] MASK_MUL   = 8'h03;
  // Reset values
  localparam logic [15:0] RST_PC   = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [7:0]  RST_SREG = 8'h00;
  // Cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // Opcodes
  localparam logic [5:0] OP_ADD = 6'h00, OP_ADD_CARRY = 6'h01, OP_WORD_PLUS_CONSTANT = 6'h02,
    OP_SUB = 6'h03, OP_DIFFERENCE_CONSTANT = 6'h04, OP_DIFFERENCE_WITH_BORROW = 6'h05,
    OP_CONSTANT_DIFFERENCE_WITH_BORROW = 6'h06, OP_WORD_MINUS_CONSTANT = 6'h07, OP_AND = 6'h08,
    OP_MASK_WITH_CONSTANT = 6'h09, OP_OR = 6'h0A, OP_MERGE_WITH_CONSTANT = 6'h0B,
    OP_ZERO_SIGN_PROBE = 6'h0C, OP_UNSIGNED_PRODUCT = 6'h0D, OP_SIGNED_PRODUCT = 6'h0E,
    OP_MIXED_SIGN_PRODUCT = 6'h0F, OP_FRACTION_PRODUCT_UNSIGNED = 6'h10,
    OP_FRACTION_PRODUCT_SIGNED = 6'h11, OP_FRACTION_PRODUCT_MIXED = 6'h12,
    OP_POINTER_JUMP = 6'h13, OP_POINTER_CALL = 6'h14, OP_EQUAL_COMPARE_SKIP = 6'h15,
    OP_COMPARE = 6'h16, OP_COMPARE_CARRY = 6'h17, OP_IMMEDIATE_COMPARE = 6'h18,
    OP_SKIP_REG_BIT_CLEAR = 6'h19, OP_SKIP_REG_BIT_SET = 6'h1A, OP_SKIP_IO_BIT_CLEAR = 6'h1B,
    OP_SKIP_IO_BIT_SET = 6'h1C, OP_BRANCH_SIGNED_GE = 6'h1D, OP_BRANCH_SIGNED_LESS = 6'h1E,
    OP_BRANCH_HALF_CARRY_ON = 6'h1F, OP_BRANCH_HALF_CARRY_OFF = 6'h20,
    OP_BRANCH_OVERFLOW_ON = 6'h21, OP_BRANCH_OVERFLOW_OFF = 6'h22,
    OP_BRANCH_UNSIGNED_GE = 6'h23, OP_BRANCH_UNSIGNED_LESS = 6'h24,
    OP_BRANCH_COPY_FLAG_ON = 6'h25, OP_BRANCH_COPY_FLAG_OFF = 6'h26;
  localparam logic [5:0] OP_LAST = 6'h26;
endpackage : cabe_pkg
`default_nettype wire

// *** cabe_exec_unit.sv ***
// Purpose: Execution unit for arithmetic, logic, multiply, compare,
//          skip, pointer jump/call and conditional branch operations.
// Assumes: APB slave; one clock mclk; operands held in registers.
// Notes:   Writing the command register issues an operation.
//
// Contract
// [RQ1] Add and add-with-carry store sum, set Z C N V H, one cycle.
// [RQ2] Word add/subtract constant on pair, set Z C N V S, two cycles.
// [RQ3] Subtract register or constant stores difference, Z C N V H, one cycle.
// [RQ4] Subtract with borrow stores d-op-carry, Z C N V H, one cycle.
// [RQ5] AND stores result, sets Z N V only, carry kept, one cycle; code also updates S.
// [RQ6] OR stores result, sets Z N V only, one cycle; code also updates S.
// [RQ7] Probe ANDs register with itself, sets Z N V, one cycle.
// [RQ8] Integer products go to fixed result pair, set Z C, two cycles.
// [RQ9] Fractional products shift left one, to result pair, Z C, two cycles.
// [RQ10] Pointer jump loads PC from Z pointer, no flags, two cycles.
// [RQ11] Pointer call pushes return address, PC from Z, three cycles.
// [RQ12] Equal compare skips next instruction on match, no flags, 1/2/3 cycles.
// [RQ13] Compares set Z N V C H without storing, one cycle.
// [RQ14] Register bit skips on clear or set, no flags, 1/2/3 cycles.
// [RQ15] I/O bit skips on clear or set, no flags, 1/2/3 cycles.
// [RQ16] Signed greater-or-equal branches when N xor V is zero.
// [RQ17] Signed less branches when N xor V is one.
// [RQ18] Half-carry branches on H set or clear.
// [RQ19] Overflow branches on V set or clear, flags kept.
// [RQ20] Unsigned branches on carry clear or set.
// [RQ21] Copy-flag branches on T set or clear, no flags.
// [RQ22] Branch 1 or 2 cycles; skip 1, 2, or 3 for two-word.
// [RQ23] Sign flag is N xor V whenever flags update; code keeps S unchanged on products, which update only Z C.
`default_nettype none
module cabe_exec_unit #(
  parameter int unsigned ADDR_W = cabe_pkg::AW
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr
);
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 6 and 32");
  end

  logic [5:0]  op_r;
  logic [1:0]  cnt_r;
  logic [1:0]  cyc_r;
  logic [15:0] opa_r;
  logic [11:0] opb_r;
  logic [7:0]  sreg_r;
  logic [15:0] pc_r;
  logic [15:0] zptr_r;
  logic [7:0]  io_r;
  logic [15:0] result_r;
  logic [15:0] stack_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic        busy;
  logic        commit;
  logic        acc;
  logic        wr;
  logic        issue;
  logic        legal;
  logic        mapped;
  logic        ro_hit;
  logic [31:0] rd_val;
  logic [5:0]  xop;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [2:0]  bsel;
  logic [15:0] pinc;
  logic [7:0]  ad;
  logic [7:0]  sd;
  logic [15:0] wd;
  logic [15:0] prod;
  logic [15:0] umul_chk;
  logic        tk;
  logic [15:0] res;
  logic [7:0]  fm;
  logic [7:0]  fnew;
  logic        fz;
  logic        fc;
  logic        fneg;
  logic        fv;
  logic        fh;
  logic        st_b;
  logic        st_w;
  logic        st_r;
  logic        jmp;
  logic        push;
  logic [15:0] tgt;
  logic [1:0]  cyc;

  // Address match against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] ad_i, input logic [7:0] ofs);
    hit = (ad_i == ADDR_W'(ofs));
  endfunction : hit

  // Half carry, overflow and carry of an 8-bit add or subtract
  function automatic logic [2:0] hvc(input logic [7:0] x, input logic [7:0] y,
                                     input logic [7:0] r, input logic sub);
    logic [7:0] xx;
    logic [7:0] rr;
    logic [7:0] yy;
    logic [7:0] cb;
    xx = sub ? ~x : x;
    rr = sub ? ~r : r;
    yy = sub ? ~y : y;
    cb = (xx & y) | (y & ~rr) | (~rr & xx);
    hvc = {cb[3], (x[7] & yy[7] & ~r[7]) | (~x[7] & ~yy[7] & r[7]), cb[7]};
  endfunction : hvc

  // Bus phase and operation control terms
  assign busy   = (cnt_r != 2'h0);
  assign commit = (cnt_r == cabe_pkg::CYC_ONE);
  assign acc    = psel & penable & pready_r;
  assign wr     = acc & pwrite;
  assign legal  = (pwdata[5:0] <= cabe_pkg::OP_LAST);
  assign issue  = wr & hit(paddr, cabe_pkg::OFS_CMD) & legal;
  assign xop    = busy ? op_r : pwdata[5:0];
  assign a      = opa_r[7:0];
  assign b      = opb_r[7:0];
  assign bsel   = opb_r[cabe_pkg::OPB_BIT_LSB +: 3];
  assign pinc   = pc_r + 16'h0001;
  assign umul_chk = {8'h00, a} * {8'h00, b};

  // Adder, subtractor, word unit and multiplier
  always_comb begin
    logic signed [8:0] ma;
    logic signed [8:0] mb;
    logic signed [17:0] p18;
    ma = {(xop != cabe_pkg::OP_UNSIGNED_PRODUCT) & (xop != cabe_pkg::OP_FRACTION_PRODUCT_UNSIGNED) & a[7], a};
    mb = {((xop == cabe_pkg::OP_SIGNED_PRODUCT) | (xop == cabe_pkg::OP_FRACTION_PRODUCT_SIGNED)) & b[7], b};
    p18 = ma * mb;
    ad = a + b + {7'h00, (xop == cabe_pkg::OP_ADD_CARRY) & sreg_r[cabe_pkg::FL_C]};
    sd = a - b - {7'h00, ((xop == cabe_pkg::OP_DIFFERENCE_WITH_BORROW) |
         (xop == cabe_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW) |
         (xop == cabe_pkg::OP_COMPARE_CARRY)) & sreg_r[cabe_pkg::FL_C]};
    wd = (xop == cabe_pkg::OP_WORD_MINUS_CONSTANT) ? opa_r - {10'h000, b[5:0]}
                                                   : opa_r + {10'h000, b[5:0]};
    prod = p18[15:0];
  end

  // Skip and branch conditions
  always_comb begin
    case (xop)
      cabe_pkg::OP_EQUAL_COMPARE_SKIP:    tk = (a == b);
      cabe_pkg::OP_SKIP_REG_BIT_CLEAR:    tk = ~a[bsel];
      cabe_pkg::OP_SKIP_REG_BIT_SET:      tk = a[bsel];
      cabe_pkg::OP_SKIP_IO_BIT_CLEAR:     tk = ~io_r[bsel];
      cabe_pkg::OP_SKIP_IO_BIT_SET:       tk = io_r[bsel];
      cabe_pkg::OP_BRANCH_SIGNED_GE:      tk = ~(sreg_r[cabe_pkg::FL_N] ^ sreg_r[cabe_pkg::FL_V]);
      cabe_pkg::OP_BRANCH_SIGNED_LESS:    tk = sreg_r[cabe_pkg::FL_N] ^ sreg_r[cabe_pkg::FL_V];
      cabe_pkg::OP_BRANCH_HALF_CARRY_ON:  tk = sreg_r[cabe_pkg::FL_H];
      cabe_pkg::OP_BRANCH_HALF_CARRY_OFF: tk = ~sreg_r[cabe_pkg::FL_H];
      cabe_pkg::OP_BRANCH_OVERFLOW_ON:    tk = sreg_r[cabe_pkg::FL_V];
      cabe_pkg::OP_BRANCH_OVERFLOW_OFF:   tk = ~sreg_r[cabe_pkg::FL_V];
      cabe_pkg::OP_BRANCH_UNSIGNED_GE:    tk = ~sreg_r[cabe_pkg::FL_C];
      cabe_pkg::OP_BRANCH_UNSIGNED_LESS:  tk = sreg_r[cabe_pkg::FL_C];
      cabe_pkg::OP_BRANCH_COPY_FLAG_ON:   tk = sreg_r[cabe_pkg::FL_T];
      cabe_pkg::OP_BRANCH_COPY_FLAG_OFF:  tk = ~sreg_r[cabe_pkg::FL_T];
      default:                            tk = 1'b0;
    endcase
  end

  // Result, flags, program counter and cycle count per operation
  always_comb begin
    res = 16'h0000;
    fm = 8'h00;
    {fz, fc, fneg, fv, fh} = 5'h00;
    {st_b, st_w, st_r, jmp, push} = 5'h00;
    tgt = pinc;
    cyc = cabe_pkg::CYC_ONE;
    unique case (xop)
      // [RQ1] byte addition
      cabe_pkg::OP_ADD, cabe_pkg::OP_ADD_CARRY: begin
        res = {8'h00, ad};
        {fh, fv, fc} = hvc(a, b, ad, 1'b0);
        fz = (ad == 8'h00);
        fm = cabe_pkg::MASK_ARITH;
        st_b = 1'b1;
      end
      // [RQ3] [RQ4] [RQ13] byte subtraction and compares
      cabe_pkg::OP_SUB, cabe_pkg::OP_DIFFERENCE_CONSTANT, cabe_pkg::OP_DIFFERENCE_WITH_BORROW,
      cabe_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW, cabe_pkg::OP_COMPARE,
      cabe_pkg::OP_COMPARE_CARRY, cabe_pkg::OP_IMMEDIATE_COMPARE: begin
        res = {8'h00, sd};
        {fh, fv, fc} = hvc(a, b, sd, 1'b1);
        fz = (sd == 8'h00);
        if (xop == cabe_pkg::OP_DIFFERENCE_WITH_BORROW || xop == cabe_pkg::OP_COMPARE_CARRY ||
            xop == cabe_pkg::OP_CONSTANT_DIFFERENCE_WITH_BORROW) begin
          fz = fz & sreg_r[cabe_pkg::FL_Z]; // Zero carries across bytes
        end
        fm = cabe_pkg::MASK_ARITH;
        st_b = (xop != cabe_pkg::OP_COMPARE) && (xop != cabe_pkg::OP_COMPARE_CARRY) &&
               (xop != cabe_pkg::OP_IMMEDIATE_COMPARE);
      end
      // [RQ2] sixteen-bit pair arithmetic
      cabe_pkg::OP_WORD_PLUS_CONSTANT, cabe_pkg::OP_WORD_MINUS_CONSTANT: begin
        res = wd;
        fz = (wd == 16'h0000);
        if (xop == cabe_pkg::OP_WORD_PLUS_CONSTANT) begin
          fv = ~opa_r[15] & wd[15];
          fc = opa_r[15] & ~wd[15];
        end else begin
          fv = opa_r[15] & ~wd[15];
          fc = ~opa_r[15] & wd[15];
        end
        fm = cabe_pkg::MASK_WORD;
        st_w = 1'b1;
        cyc = cabe_pkg::CYC_TWO;
      end
      // [RQ5] [RQ6] [RQ7] logic, carry untouched
      cabe_pkg::OP_AND, cabe_pkg::OP_MASK_WITH_CONSTANT, cabe_pkg::OP_OR,
      cabe_pkg::OP_MERGE_WITH_CONSTANT, cabe_pkg::OP_ZERO_SIGN_PROBE: begin
        if (xop == cabe_pkg::OP_OR || xop == cabe_pkg::OP_MERGE_WITH_CONSTANT) begin
          res = {8'h00, a | b};
        end else if (xop == cabe_pkg::OP_ZERO_SIGN_PROBE) begin
          res = {8'h00, a & a};
        end else begin
          res = {8'h00, a & b};
        end
        fz = (res[7:0] == 8'h00);
        fm = cabe_pkg::MASK_LOGIC;
        st_b = (xop != cabe_pkg::OP_ZERO_SIGN_PROBE);
      end
      // [RQ8] [RQ9] products into the fixed pair
      cabe_pkg::OP_UNSIGNED_PRODUCT, cabe_pkg::OP_SIGNED_PRODUCT, cabe_pkg::OP_MIXED_SIGN_PRODUCT,
      cabe_pkg::OP_FRACTION_PRODUCT_UNSIGNED, cabe_pkg::OP_FRACTION_PRODUCT_SIGNED,
      cabe_pkg::OP_FRACTION_PRODUCT_MIXED: begin
        res = (xop >= cabe_pkg::OP_FRACTION_PRODUCT_UNSIGNED) ? {prod[14:0], 1'b0} : prod;
        fc = prod[15];
        fz = (res == 16'h0000);
        fm = cabe_pkg::MASK_MUL;
        st_r = 1'b1;
        cyc = cabe_pkg::CYC_TWO;
      end
      // [RQ10] [RQ11] pointer jump and call
      cabe_pkg::OP_POINTER_JUMP, cabe_pkg::OP_POINTER_CALL: begin
        jmp = 1'b1;
        tgt = zptr_r;
        push = (xop == cabe_pkg::OP_POINTER_CALL);
        cyc = push ? cabe_pkg::CYC_THREE : cabe_pkg::CYC_TWO;
      end
      // [RQ12] [RQ14] [RQ15] [RQ22] skips over one or two words
      cabe_pkg::OP_EQUAL_COMPARE_SKIP, cabe_pkg::OP_SKIP_REG_BIT_CLEAR,
      cabe_pkg::OP_SKIP_REG_BIT_SET, cabe_pkg::OP_SKIP_IO_BIT_CLEAR,
      cabe_pkg::OP_SKIP_IO_BIT_SET: begin
        if (tk) begin
          jmp = 1'b1;
          tgt = opb_r[cabe_pkg::OPB_TWO_WORD] ? pc_r + 16'h0003 : pc_r + 16'h0002;
          cyc = opb_r[cabe_pkg::OPB_TWO_WORD] ? cabe_pkg::CYC_THREE : cabe_pkg::CYC_TWO;
        end
      end
      // [RQ16] [RQ17] [RQ18] [RQ19] [RQ20] [RQ21] [RQ22] relative branches
      default: begin
        if (tk) begin
          jmp = 1'b1;
          tgt = pinc + {{8{b[7]}}, b};
          cyc = cabe_pkg::CYC_TWO;
        end
      end
    endcase
    fneg = (st_w || xop == cabe_pkg::OP_WORD_MINUS_CONSTANT) ? res[15] : res[7];
    fnew = 8'h00;
    fnew[cabe_pkg::FL_Z] = fz;
    fnew[cabe_pkg::FL_C] = fc;
    fnew[cabe_pkg::FL_N] = fneg;
    fnew[cabe_pkg::FL_V] = fv;
    fnew[cabe_pkg::FL_H] = fh;
    // [RQ23] sign from negative and overflow
    fnew[cabe_pkg::FL_S] = fneg ^ fv;
  end

  // Read mux and map checks
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    ro_hit = 1'b0;
    if (hit(paddr, cabe_pkg::OFS_CMD)) begin
      rd_val = {26'h0, op_r};
    end else if (hit(paddr, cabe_pkg::OFS_OPA)) begin
      rd_val = {16'h0, opa_r};
    end else if (hit(paddr, cabe_pkg::OFS_OPB)) begin
      rd_val = {20'h0, opb_r};
    end else if (hit(paddr, cabe_pkg::OFS_FLAGS)) begin
      rd_val = {24'h0, sreg_r};
    end else if (hit(paddr, cabe_pkg::OFS_PC)) begin
      rd_val = {16'h0, pc_r};
    end else if (hit(paddr, cabe_pkg::OFS_ZPTR)) begin
      rd_val = {16'h0, zptr_r};
    end else if (hit(paddr, cabe_pkg::OFS_IOVAL)) begin
      rd_val = {24'h0, io_r};
    end else if (hit(paddr, cabe_pkg::OFS_RESULT)) begin
      rd_val = {16'h0, result_r};
      ro_hit = 1'b1;
    end else if (hit(paddr, cabe_pkg::OFS_STATUS)) begin
      rd_val = {26'h0, cyc_r, 3'h0, busy};
      ro_hit = 1'b1;
    end else if (hit(paddr, cabe_pkg::OFS_STACK)) begin
      rd_val = {16'h0, stack_r};
      ro_hit = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer, held off while an operation runs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & penable & ~pready_r & ~busy;
      prdata_r  <= (psel & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr_r <= psel & (~mapped | (pwrite & ro_hit) |
                   (pwrite & hit(paddr, cabe_pkg::OFS_CMD) & ~legal));
    end
  end

  // [RQ22] operation issue and cycle countdown
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op_r  <= 6'h00;
      cnt_r <= 2'h0;
      cyc_r <= 2'h0;
    end else if (issue) begin
      op_r  <= pwdata[5:0];
      cnt_r <= cyc;
      cyc_r <= cyc;
    end else if (busy) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // Destination operand, written back at commit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opa_r <= cabe_pkg::RST_DATA;
    end else if (commit && st_w) begin
      opa_r <= res;
    end else if (commit && st_b) begin
      opa_r[7:0] <= res[7:0];
    end else if (wr && hit(paddr, cabe_pkg::OFS_OPA)) begin
      opa_r <= pwdata[15:0];
    end
  end

  // Source operand, pointer and I/O byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opb_r  <= 12'h000;
      zptr_r <= cabe_pkg::RST_DATA;
      io_r   <= 8'h00;
    end else begin
      if (wr && hit(paddr, cabe_pkg::OFS_OPB)) opb_r <= pwdata[11:0];
      if (wr && hit(paddr, cabe_pkg::OFS_ZPTR)) zptr_r <= pwdata[15:0];
      if (wr && hit(paddr, cabe_pkg::OFS_IOVAL)) io_r <= pwdata[7:0];
    end
  end

  // Status flags, only masked bits change at commit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sreg_r <= cabe_pkg::RST_SREG;
    end else if (commit) begin
      sreg_r <= (sreg_r & ~fm) | (fnew & fm);
    end else if (wr && hit(paddr, cabe_pkg::OFS_FLAGS)) begin
      sreg_r <= pwdata[7:0];
    end
  end

  // Program counter, product pair and pushed return address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_r     <= cabe_pkg::RST_PC;
      result_r <= cabe_pkg::RST_DATA;
      stack_r  <= cabe_pkg::RST_DATA;
    end else if (commit) begin
      pc_r <= jmp ? tgt : pinc;
      if (st_r) result_r <= res;
      if (push) stack_r <= pinc;
    end else if (wr && hit(paddr, cabe_pkg::OFS_PC)) begin
      pc_r <= pwdata[15:0];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Checks on operation behaviour
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_add_one_cycle: assert property (issue && pwdata[5:0] == cabe_pkg::OP_ADD |=> commit) // [RQ1]
    else $error("add did not finish in one cycle");
  a_word_two_cycle: assert property (issue && pwdata[5:0] == cabe_pkg::OP_WORD_PLUS_CONSTANT // [RQ2]
    |=> cnt_r == 2'h2 ##1 commit ##1 !busy) else $error("word add not two cycles");
  a_mul_pair: assert property (commit && op_r == cabe_pkg::OP_UNSIGNED_PRODUCT // [RQ8]
    |=> result_r == $past(umul_chk)) else $error("unsigned product wrong");
  a_sign_flag: assert property (commit && fm[cabe_pkg::FL_S] // [RQ23]
    |=> sreg_r[cabe_pkg::FL_S] == (sreg_r[cabe_pkg::FL_N] ^ sreg_r[cabe_pkg::FL_V]))
    else $error("sign flag not N xor V");
  a_logic_carry: assert property (commit && op_r == cabe_pkg::OP_AND // [RQ5]
    |=> $stable(sreg_r[cabe_pkg::FL_C])) else $error("AND changed carry");
  a_cmp_nostore: assert property (commit && op_r == cabe_pkg::OP_COMPARE // [RQ13]
    |=> $stable(opa_r)) else $error("compare stored a result");
  a_jump_target: assert property (commit && op_r == cabe_pkg::OP_POINTER_JUMP // [RQ10]
    |=> pc_r == $past(zptr_r) && $stable(sreg_r)) else $error("pointer jump wrong");
  a_call_push: assert property (issue && pwdata[5:0] == cabe_pkg::OP_POINTER_CALL // [RQ11]
    |=> busy [*3] ##1 stack_r == $past(pc_r, 3) + 16'h0001) else $error("pointer call wrong");
  a_branch_time: assert property (issue && pwdata[5:0] >= cabe_pkg::OP_BRANCH_SIGNED_GE // [RQ22]
    |=> ##[0:1] commit ##1 !busy) else $error("branch took over two cycles");

  c_branch_taken: cover property (commit && op_r == cabe_pkg::OP_BRANCH_SIGNED_LESS && jmp);
  c_skip_two_word: cover property (commit && op_r == cabe_pkg::OP_SKIP_IO_BIT_SET && cyc_r == 2'h3);
  c_fraction_mul: cover property (commit && op_r == cabe_pkg::OP_FRACTION_PRODUCT_SIGNED);
endmodule : cabe_exec_unit
`default_nettype wire

// *** tb_core_alu_branch_exec.sv ***
// Purpose: Self-checking bench for the execution unit over APB.
// Assumes: Registered pready; a running operation stalls the bus.
// Notes:   Expected replies are queued at setup, compared on completion.
`default_nettype none
module tb_core_alu_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, f, io;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  logic [15:0] a, pc, z, e, p;
  logic [16:0] w;
  logic [17:0] fl;
  logic [11:0] b;
  logic [5:0]  ops[$];
  int          errors, checks_done, cycles, seed;

  cabe_exec_unit dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock, 10 ns period
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end

  // Compare one completed transfer with the oldest note
  task automatic cmp_reply(input logic [32:0] seen);
    checks_done++;
    if (exp_q.size() == 0 || seen !== exp_q[0]) begin
      errors++;
      $display("CHECK FAILED apb_reply at %0h expected %h seen %h", paddr, exp_q[0], seen);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask : cmp_reply

  // Watch the bus for completed transfers
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) cmp_reply({pslverr, prdata});
  end

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr_en, input logic [7:0] ad, input logic [31:0] wd, input logic [32:0] ex);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= ad;
    pwdata  <= wd;
    exp_q.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h0, {1'b0, ex});
  endtask : rd

  // Load random operands, then issue the command
  task automatic run(input logic [5:0] c);
    wr(8'h04, {16'h0, a});
    wr(8'h08, {20'h0, b});
    wr(8'h0C, {24'h0, f});
    wr(8'h10, {16'h0, pc});
    wr(8'h14, {16'h0, z});
    wr(8'h18, {24'h0, io});
    wr(8'h00, {26'h0, c});
  endtask : run

  task automatic rnd;
    {a, b, f, pc, z, io} = {32'($urandom), 32'($urandom), 12'($urandom)};
  endtask : rnd

  // Byte sum or difference with flags C0 Z1 N2 V3 S4 H5 recomputed
  function automatic logic [15:0] arith(input logic [7:0] x, y, o, input logic ci, sb);
    logic [8:0] r;
    logic [4:0] h;
    r = sb ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
    h = sb ? {1'b0, x[3:0]} - y[3:0] - ci : {1'b0, x[3:0]} + y[3:0] + ci;
    o[0] = r[8];
    o[1] = (r[7:0] == 8'h00);
    o[2] = r[7];
    o[3] = sb ? (x[7] != y[7]) && (r[7] != x[7]) : (x[7] == y[7]) && (r[7] != x[7]);
    o[4] = r[7] ^ o[3];
    o[5] = h[4];
    return {r[7:0], o};
  endfunction : arith

  // Cycle count and next PC of program-flow operations
  function automatic logic [17:0] flow(input logic [5:0] c);
    logic t;
    case (c)
      6'h13: return {2'h2, z};
      6'h14: return {2'h3, z};
      6'h15: t = (a[7:0] == b[7:0]);
      6'h19: t = !a[b[10:8]];
      6'h1A: t = a[b[10:8]];
      6'h1B: t = !io[b[10:8]];
      6'h1C: t = io[b[10:8]];
      6'h1D: t = !(f[2] ^ f[3]);
      6'h1E: t = f[2] ^ f[3];
      6'h1F: t = f[5];
      6'h20: t = !f[5];
      6'h21: t = f[3];
      6'h22: t = !f[3];
      6'h23: t = !f[0];
      6'h24: t = f[0];
      6'h25: t = f[6];
      default: t = !f[6];
    endcase
    if (c > 6'h1C) return t ? {2'h2, pc + {{8{b[7]}}, b[7:0]} + 16'h1} : {2'h1, pc + 16'h1};
    return !t ? {2'h1, pc + 16'h1} : b[11] ? {2'h3, pc + 16'h3} : {2'h2, pc + 16'h2};
  endfunction : flow

  // Main sequence
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = $urandom(65040);
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    ops = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h16, 6'h17, 6'h18};
    foreach (ops[i]) repeat (4) begin
      rnd();
      run(ops[i]);
      e = arith(a[7:0], b[7:0], f, ops[i] inside {6'h01, 6'h05, 6'h06, 6'h17} ? f[0] : 1'b0, ops[i] > 6'h01);
      if (ops[i] inside {6'h05, 6'h06, 6'h17}) e[1] = e[1] & f[1];
      rd(8'h04, {16'h0, a[15:8], ops[i] > 6'h15 ? a[7:0] : e[15:8]});
      rd(8'h0C, {24'h0, e[7:0]});
      rd(8'h20, 32'h10);
    end
    ops = '{6'h02, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12};
    foreach (ops[i]) repeat (4) begin
      rnd();
      run(ops[i]);
      e = a;
      w = ops[i] == 6'h07 ? {1'b0, a} - b[5:0] : {1'b0, a} + b[5:0];
      p = {{8{a[7] && !(ops[i] inside {6'h0D, 6'h10})}}, a[7:0]} *
          {{8{b[7] && ops[i] inside {6'h0E, 6'h11}}}, b[7:0]};
      if (ops[i] < 6'h08) e = w[15:0];
      if (ops[i] < 6'h08) f[4:0] = {w[15] ^ (a[15] ^ w[15]) & (ops[i] == 6'h07 ? a[15] : w[15]),
        (a[15] ^ w[15]) & (ops[i] == 6'h07 ? a[15] : w[15]), w[15], w[15:0] == 16'h0, w[16]};
      if (ops[i] inside {[6'h08:6'h0C]}) begin
        e[7:0] = ops[i] > 6'h0B ? a[7:0] : ops[i] > 6'h09 ? a[7:0] | b[7:0] : a[7:0] & b[7:0];
        f[4:1] = {e[7], 1'b0, e[7], e[7:0] == 8'h0};
      end
      if (ops[i] > 6'h0C) f[1:0] = {p[14:0] == 15'h0 && (ops[i] > 6'h0F || !p[15]), p[15]};
      if (ops[i] > 6'h0F) p = p << 1;
      rd(8'h04, {16'h0, e});
      rd(8'h0C, {24'h0, f});
      if (ops[i] > 6'h0C) rd(8'h1C, {16'h0, p});
      rd(8'h20, ops[i] inside {[6'h08:6'h0C]} ? 32'h10 : 32'h20);
    end
    ops = '{6'h13, 6'h14, 6'h15, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24,
      6'h25, 6'h26};
    foreach (ops[i]) repeat (6) begin
      rnd();
      if (b[9]) b[7:0] = a[7:0];
      run(ops[i]);
      fl = flow(ops[i]);
      rd(8'h10, {16'h0, fl[15:0]});
      rd(8'h0C, {24'h0, f});
      rd(8'h20, {26'h0, fl[17:16], 4'h0});
      if (ops[i] == 6'h14) rd(8'h24, {16'h0, pc + 16'h1});
    end
    // Refused accesses: unmapped, read-only, illegal opcode
    apb(1'b0, 8'h28, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h1C, 32'h5A, {1'b1, 32'h0});
    apb(1'b1, 8'h00, 32'h27, {1'b1, 32'h0});
    rd(8'h10, {16'h0, fl[15:0]});
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule : tb_core_alu_branch_exec
`default_nettype wire
